// *** design/dbw_regs.vh ***
// Register indices, field positions and reset values of the debug breakpoint unit
`ifndef DBW_REGS_VH
`define DBW_REGS_VH
// Register indices (word index; byte address is four times the index)
`define DBW_IDX_EVENT_DATA 8'h16
`define DBW_IDX_STOP_VEC 8'h18
`define DBW_IDX_SCRATCH 8'h20
`define DBW_IDX_IBP_ADDR 8'h30
`define DBW_IDX_IBP_CTRL 8'h40
`define DBW_IDX_DW_FIRST 8'h50
`define DBW_IDX_DW_SECOND 8'h60
`define DBW_IDX_DW_CTRL 8'h70
`define DBW_IDX_RW_MASK 8'h80
`define DBW_IDX_RW_VALUE 8'h90
`define DBW_IDX_RW_CTRL 8'h9C
// Added registers: cause, status, mask, mode
`define DBW_IDX_CAUSE 8'hA0
`define DBW_IDX_IRQ_STAT 8'hA1
`define DBW_IDX_IRQ_MASK 8'hA2
`define DBW_IDX_MODE 8'hA3
// Control field positions
`define DBW_CTRL_EN 0
`define DBW_CTRL_INV 1
`define DBW_CTRL_LOAD 2
`define DBW_CTRL_CORE_LO 16
`define DBW_CTRL_CORE_HI 23
// Writable control bits; reserved bits are dropped on write
`define DBW_IBP_CTRL_MASK 32'h00FF0003
`define DBW_DW_CTRL_MASK 32'h00FF0007
`define DBW_RW_CTRL_MASK 32'h00FF0003
// Cause codes
`define DBW_CAUSE_IBP 3'h3
`define DBW_CAUSE_DW 3'h4
`define DBW_CAUSE_RW 3'h5
// Interrupt status bits
`define DBW_IRQ_IBP 0
`define DBW_IRQ_DW 1
`define DBW_IRQ_RW 2
// Reset values
`define DBW_CTRL_RST 32'h00000000
`define DBW_WORD_RST 32'h00000000
`endif

// *** design/dbw_unit.v ***
// Debug breakpoint, watchpoint and core stop unit with a classic Wishbone slave
// Operation
// - Data watchpoint hit loads event data with the access's effective address.
// - Resource watchpoint hit loads event data with the matching resource identifier.
// - Stop vector has one bit per core; set bit stops core outside debug.
// - After leaving debug, cores marked in the stop vector do not run.
// - Eight shared 32-bit scratch words, reachable from debug and configuration sides.
// - Four instruction breakpoints; enabled one fires when PC matches its address.
// - Control bits 23:16 enable each unit per core, reset to zero.
// - Breakpoint control bit 1 set fires on PC not equal to address.
// - Control bit 0 enables the unit; all units disabled after reset.
// - Four data watchpoints, each bounded by first and second address registers.
// - Data watchpoints fire on stores always, on loads only if bit 2 set.
// - Invert clear: fire when first <= address <= second.
// - Invert set: fire when address < second or address > first... outside, exclusive.
// - Four resource watchpoints, each with mask and compare value registers.
// - Invert clear: fire when identifier AND mask equals compare value.
// - Invert set: fire when masked identifier differs from compare value.
// - Cause recorded as 3 breakpoint, 4 data watch, 5 resource watch.
// - Several hits at once: breakpoint before data watch before resource watch, then the lowest-numbered unit of that class is recorded.
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
`include "dbw_regs.vh"
module dbw_unit #(
  parameter NUM_CORES = 8,
  parameter NUM_UNITS = 4
) (
  input wire clk_i, // Tile clock
  input wire rst_i, // Synchronous reset, active high
  // Wishbone slave, debug register space
  input wire wb_cyc_i, // Bus cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write enable
  input wire [9:0] wb_adr_i, // Byte address
  input wire [3:0] wb_sel_i, // Byte lanes
  input wire [31:0] wb_dat_i, // Write data
  output reg [31:0] wb_dat_o, // Read data
  output reg wb_ack_o, // Acknowledge
  // Configuration-space port to the scratch words
  input wire cfg_req_i, // Scratch access strobe
  input wire cfg_we_i, // Scratch write
  input wire [2:0] cfg_idx_i, // Scratch word index
  input wire [31:0] cfg_wdata_i, // Scratch write data
  input wire cfg_write_lock_i, // Restrict config side to read-only
  output reg [31:0] cfg_rdata_o, // Scratch read data
  // Pipeline side
  input wire iss_valid_i, // Instruction issued this cycle
  input wire [2:0] iss_core_i, // Issuing logical core
  input wire [31:0] iss_pc_i, // Program counter of issued instruction
  input wire mem_valid_i, // Instruction performs a load or store
  input wire mem_store_i, // 1 store, 0 load
  input wire [31:0] mem_addr_i, // Effective address
  input wire res_valid_i, // Instruction uses a resource
  input wire [31:0] res_id_i, // Resource identifier
  input wire debug_mode_i, // Tile is in debug mode
  output reg dbg_req_o, // One-cycle debug interrupt request
  output reg [NUM_CORES-1:0] core_run_ok_o, // Per-core run permission
  output wire irq_o // Level interrupt to software
);

  // Register storage
  reg [31:0] event_data_reg;
  reg [NUM_CORES-1:0] stop_vec_reg;
  reg [31:0] scratch_reg [0:7];
  reg [31:0] ibp_addr_reg [0:NUM_UNITS-1];
  reg [31:0] ibp_ctrl_reg [0:NUM_UNITS-1];
  reg [31:0] dw_first_reg [0:NUM_UNITS-1];
  reg [31:0] dw_second_reg [0:NUM_UNITS-1];
  reg [31:0] dw_ctrl_reg [0:NUM_UNITS-1];
  reg [31:0] rw_mask_reg [0:NUM_UNITS-1];
  reg [31:0] rw_value_reg [0:NUM_UNITS-1];
  reg [31:0] rw_ctrl_reg [0:NUM_UNITS-1];
  reg [2:0] cause_reg;
  reg [1:0] src_num_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  reg debug_mode_d_reg;

  // Byte-lane merge, used by every bus-writable word but the interrupt mask and status
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer b;
    begin
      lane_merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          lane_merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  // Unit armed for this core: enable bit and per-core bit both set
  function armed;
    input [31:0] ctrl;
    input [2:0] core;
    begin
      armed = ctrl[`DBW_CTRL_EN] & ctrl[`DBW_CTRL_CORE_LO + core];
    end
  endfunction

  // Word index decode; low address bits are ignored, every register is a whole word
  wire [7:0] idx = wb_adr_i[9:2];
  // A request already acknowledged is not taken a second time
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;

  // Hit detection across all units
  // Purely combinational, so the debug request leaves one edge after the issue
  reg [NUM_UNITS-1:0] ibp_hit;
  reg [NUM_UNITS-1:0] dw_hit;
  reg [NUM_UNITS-1:0] rw_hit;
  integer u;
  always @* begin
    ibp_hit = {NUM_UNITS{1'b0}};
    dw_hit = {NUM_UNITS{1'b0}};
    rw_hit = {NUM_UNITS{1'b0}};
    for (u = 0; u < NUM_UNITS; u = u + 1) begin
      // Breakpoint: PC equality, or inequality when inverted
      if (iss_valid_i && armed(ibp_ctrl_reg[u], iss_core_i)) begin
        if (ibp_ctrl_reg[u][`DBW_CTRL_INV]) begin
          ibp_hit[u] = iss_pc_i != ibp_addr_reg[u];
        end else begin
          ibp_hit[u] = iss_pc_i == ibp_addr_reg[u];
        end
      end
      // Data watchpoint: stores always qualify, loads only on request
      if (iss_valid_i && mem_valid_i && armed(dw_ctrl_reg[u], iss_core_i) &&
          (mem_store_i || dw_ctrl_reg[u][`DBW_CTRL_LOAD])) begin
        if (dw_ctrl_reg[u][`DBW_CTRL_INV]) begin
          dw_hit[u] = (mem_addr_i < dw_second_reg[u]) ||
                      (mem_addr_i > dw_first_reg[u]);
        end else begin
          dw_hit[u] = (mem_addr_i >= dw_first_reg[u]) &&
                      (mem_addr_i <= dw_second_reg[u]);
        end
      end
      // Resource watchpoint: masked identifier against the compare value
      if (iss_valid_i && res_valid_i && armed(rw_ctrl_reg[u], iss_core_i)) begin
        if (rw_ctrl_reg[u][`DBW_CTRL_INV]) begin
          rw_hit[u] = (res_id_i & rw_mask_reg[u]) != rw_value_reg[u];
        end else begin
          rw_hit[u] = (res_id_i & rw_mask_reg[u]) == rw_value_reg[u];
        end
      end
    end
  end

  // Lowest set bit, used for each class
  // Searches four units only; more units would need a wider search
  function [1:0] lowest;
    input [3:0] v;
    begin
      lowest = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
    end
  endfunction

  // Hits are ignored in debug mode; one event per instruction
  wire any_ibp = |ibp_hit;
  wire any_dw = |dw_hit;
  wire any_rw = |rw_hit;
  wire fire = ~debug_mode_i & (any_ibp | any_dw | any_rw);

  // Cause, source and event data capture; breakpoint takes priority
  // A hit outranks a bus write to event data in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      cause_reg <= 3'h0;
      src_num_reg <= 2'h0;
      event_data_reg <= `DBW_WORD_RST;
      dbg_req_o <= 1'b0;
    end else begin
      dbg_req_o <= fire;
      if (fire) begin
        if (any_ibp) begin
          cause_reg <= `DBW_CAUSE_IBP;
          src_num_reg <= lowest(ibp_hit);
        end else if (any_dw) begin
          cause_reg <= `DBW_CAUSE_DW;
          src_num_reg <= lowest(dw_hit);
          event_data_reg <= mem_addr_i;
        end else begin
          cause_reg <= `DBW_CAUSE_RW;
          src_num_reg <= lowest(rw_hit);
          event_data_reg <= res_id_i;
        end
      end else if (wb_wr && idx == `DBW_IDX_EVENT_DATA) begin
        event_data_reg <= lane_merge(event_data_reg, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Stop vector keeps only the per-core lanes; upper bits read as zero
  wire [31:0] stop_merge = lane_merge({{(32-NUM_CORES){1'b0}}, stop_vec_reg}, wb_dat_i,
                                      wb_sel_i);

  // Control and address registers written from the bus
  integer k;
  always @(posedge clk_i) begin
    if (rst_i) begin
      stop_vec_reg <= {NUM_CORES{1'b0}};
      irq_mask_reg <= 3'h0;
      // Every unit starts disabled with zeroed addresses
      for (k = 0; k < NUM_UNITS; k = k + 1) begin
        ibp_ctrl_reg[k] <= `DBW_CTRL_RST;
        dw_ctrl_reg[k] <= `DBW_CTRL_RST;
        rw_ctrl_reg[k] <= `DBW_CTRL_RST;
        ibp_addr_reg[k] <= `DBW_WORD_RST;
        dw_first_reg[k] <= `DBW_WORD_RST;
        dw_second_reg[k] <= `DBW_WORD_RST;
        rw_mask_reg[k] <= `DBW_WORD_RST;
        rw_value_reg[k] <= `DBW_WORD_RST;
      end
    end else if (wb_wr) begin
      if (idx == `DBW_IDX_STOP_VEC) begin
        stop_vec_reg <= stop_merge[NUM_CORES-1:0];
      end
      if (idx == `DBW_IDX_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask_reg <= wb_dat_i[2:0];
      end
      for (k = 0; k < NUM_UNITS; k = k + 1) begin
        if (idx == `DBW_IDX_IBP_ADDR + k[7:0]) begin
          ibp_addr_reg[k] <= lane_merge(ibp_addr_reg[k], wb_dat_i, wb_sel_i);
        end
        // Reserved control bits are dropped so they read back zero
        if (idx == `DBW_IDX_IBP_CTRL + k[7:0]) begin
          ibp_ctrl_reg[k] <= lane_merge(ibp_ctrl_reg[k], wb_dat_i, wb_sel_i) &
                             `DBW_IBP_CTRL_MASK;
        end
        if (idx == `DBW_IDX_DW_FIRST + k[7:0]) begin
          dw_first_reg[k] <= lane_merge(dw_first_reg[k], wb_dat_i, wb_sel_i);
        end
        if (idx == `DBW_IDX_DW_SECOND + k[7:0]) begin
          dw_second_reg[k] <= lane_merge(dw_second_reg[k], wb_dat_i, wb_sel_i);
        end
        if (idx == `DBW_IDX_DW_CTRL + k[7:0]) begin
          dw_ctrl_reg[k] <= lane_merge(dw_ctrl_reg[k], wb_dat_i, wb_sel_i) &
                            `DBW_DW_CTRL_MASK;
        end
        if (idx == `DBW_IDX_RW_MASK + k[7:0]) begin
          rw_mask_reg[k] <= lane_merge(rw_mask_reg[k], wb_dat_i, wb_sel_i);
        end
        if (idx == `DBW_IDX_RW_VALUE + k[7:0]) begin
          rw_value_reg[k] <= lane_merge(rw_value_reg[k], wb_dat_i, wb_sel_i);
        end
        if (idx == `DBW_IDX_RW_CTRL + k[7:0]) begin
          rw_ctrl_reg[k] <= lane_merge(rw_ctrl_reg[k], wb_dat_i, wb_sel_i) &
                            `DBW_RW_CTRL_MASK;
        end
      end
    end
  end

  // Scratch words: one set, two access paths; the debug bus wins a same-word clash
  integer s;
  always @(posedge clk_i) begin
    if (rst_i) begin
      for (s = 0; s < 8; s = s + 1) begin
        scratch_reg[s] <= `DBW_WORD_RST;
      end
      cfg_rdata_o <= 32'h00000000;
    end else begin
      // Config read returns the word as it stood before this edge
      if (cfg_req_i) begin
        cfg_rdata_o <= scratch_reg[cfg_idx_i];
      end
      for (s = 0; s < 8; s = s + 1) begin
        if (wb_wr && idx == `DBW_IDX_SCRATCH + s[7:0]) begin
          scratch_reg[s] <= lane_merge(scratch_reg[s], wb_dat_i, wb_sel_i);
        end else if (cfg_req_i && cfg_we_i && !cfg_write_lock_i && cfg_idx_i == s[2:0]) begin
          scratch_reg[s] <= cfg_wdata_i;
        end
      end
    end
  end

  // Core run permission; stop vector only bites outside debug mode
  // Reset leaves every core free to run; the mode flag is delayed to match
  always @(posedge clk_i) begin
    if (rst_i) begin
      core_run_ok_o <= {NUM_CORES{1'b1}};
      debug_mode_d_reg <= 1'b0;
    end else begin
      debug_mode_d_reg <= debug_mode_i;
      core_run_ok_o <= debug_mode_i ? {NUM_CORES{1'b1}} : ~stop_vec_reg;
    end
  end

  // Sticky interrupt status; a new event wins over a clear in the same cycle
  // Only lane 0 of a status write clears anything
  wire [2:0] irq_set = {fire & ~any_ibp & ~any_dw, fire & ~any_ibp & any_dw, fire & any_ibp};
  wire [2:0] irq_clr = (wb_wr && idx == `DBW_IDX_IRQ_STAT && wb_sel_i[0]) ? wb_dat_i[2:0] :
                       3'h0;
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // Read mux; unmapped words read zero and are still acknowledged
  reg [31:0] rd_data;
  integer r;
  always @* begin
    rd_data = 32'h00000000;
    if (idx == `DBW_IDX_EVENT_DATA) begin
      rd_data = event_data_reg;
    end
    if (idx == `DBW_IDX_STOP_VEC) begin
      rd_data = {{(32-NUM_CORES){1'b0}}, stop_vec_reg};
    end
    if (idx == `DBW_IDX_CAUSE) begin
      rd_data = {14'h0000, src_num_reg, 13'h0000, cause_reg};
    end
    if (idx == `DBW_IDX_IRQ_STAT) begin
      rd_data = {29'h00000000, irq_stat_reg};
    end
    if (idx == `DBW_IDX_IRQ_MASK) begin
      rd_data = {29'h00000000, irq_mask_reg};
    end
    if (idx == `DBW_IDX_MODE) begin
      rd_data = {31'h00000000, debug_mode_d_reg};
    end
    for (r = 0; r < 8; r = r + 1) begin
      if (idx == `DBW_IDX_SCRATCH + r[7:0]) begin
        rd_data = scratch_reg[r];
      end
    end
    for (r = 0; r < NUM_UNITS; r = r + 1) begin
      if (idx == `DBW_IDX_IBP_ADDR + r[7:0]) begin
        rd_data = ibp_addr_reg[r];
      end
      if (idx == `DBW_IDX_IBP_CTRL + r[7:0]) begin
        rd_data = ibp_ctrl_reg[r];
      end
      if (idx == `DBW_IDX_DW_FIRST + r[7:0]) begin
        rd_data = dw_first_reg[r];
      end
      if (idx == `DBW_IDX_DW_SECOND + r[7:0]) begin
        rd_data = dw_second_reg[r];
      end
      if (idx == `DBW_IDX_DW_CTRL + r[7:0]) begin
        rd_data = dw_ctrl_reg[r];
      end
      if (idx == `DBW_IDX_RW_MASK + r[7:0]) begin
        rd_data = rw_mask_reg[r];
      end
      if (idx == `DBW_IDX_RW_VALUE + r[7:0]) begin
        rd_data = rw_value_reg[r];
      end
      if (idx == `DBW_IDX_RW_CTRL + r[7:0]) begin
        rd_data = rw_ctrl_reg[r];
      end
    end
  end

  // Single-wait-state Wishbone answer
  // Read data stays on the bus until the next read
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule

// *** testbench/dbw_unit_monitor.sv ***
// Concurrent checks on the debug unit's bus, pipeline and run ports
`timescale 1ns/10ps
module dbw_unit_monitor #(
  parameter NUM_CORES = 8
) (
  input wire clk_i, // Tile clock
  input wire rst_i, // Synchronous reset
  input wire wb_cyc_i, // Bus cycle
  input wire wb_stb_i, // Strobe
  input wire wb_we_i, // Write enable
  input wire wb_ack_o, // Acknowledge
  input wire iss_valid_i, // Issue strobe
  input wire debug_mode_i, // Debug mode
  input wire dbg_req_o, // Debug request
  input wire [NUM_CORES-1:0] core_run_ok_o, // Run permission
  input wire irq_o // Level interrupt
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Bus answers one cycle after a taken request, once
  property p_ack_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_take: assert property (p_ack_take) else $error("ack missing");
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_cause;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  // A request needs an issue outside debug mode
  property p_hit_issue;
    !iss_valid_i |=> !dbg_req_o;
  endproperty
  a_hit_issue: assert property (p_hit_issue) else $error("request without issue");
  property p_hit_debug;
    debug_mode_i |=> !dbg_req_o;
  endproperty
  a_hit_debug: assert property (p_hit_debug) else $error("request in debug mode");
  // All cores run in debug; stop vector holds otherwise
  property p_run_debug;
    debug_mode_i [*2] |-> &core_run_ok_o;
  endproperty
  a_run_debug: assert property (p_run_debug) else $error("core held in debug");
  property p_run_hold;
    (!debug_mode_i && !wb_cyc_i) [*3] |-> $stable(core_run_ok_o);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("run mask drifted");
  // Interrupt moves only on a hit or a bus write
  property p_irq_rise;
    $rose(irq_o) |-> dbg_req_o || wb_ack_o;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_fall;
    $fell(irq_o) |-> wb_ack_o && wb_we_i;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
endmodule

bind dbw_unit dbw_unit_monitor #(.NUM_CORES(NUM_CORES)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .iss_valid_i(iss_valid_i),
  .debug_mode_i(debug_mode_i), .dbg_req_o(dbg_req_o),
  .core_run_ok_o(core_run_ok_o), .irq_o(irq_o)
);

// *** testbench/dbw_pipe_model.sv ***
// Behavioural pipeline issuing one instruction at a time
`timescale 1ns/10ps
module dbw_pipe_model (
  input wire clk_i, // Tile clock
  output reg iss_valid_o, // Issue strobe
  output reg [2:0] iss_core_o, // Issuing core
  output reg [31:0] iss_pc_o, // Program counter
  output reg mem_valid_o, // Load or store
  output reg mem_store_o, // Store when high
  output reg [31:0] mem_addr_o, // Effective address
  output reg res_valid_o, // Resource used
  output reg [31:0] res_id_o, // Resource identifier
  output reg dbg_mode_o // Tile in debug mode
);
  initial begin
    {iss_valid_o, mem_valid_o, mem_store_o, res_valid_o, dbg_mode_o} = 5'h00;
    iss_core_o = 3'h0;
    {iss_pc_o, mem_addr_o, res_id_o} = 96'h0;
  end
  // One cycle issue; released lines invert so stale values never match
  task issue(input [2:0] c, input [31:0] pc, input [1:0] m, input [31:0] a,
      input r, input [31:0] id);
    begin
      @(posedge clk_i);
      iss_valid_o <= 1'h1;
      iss_core_o <= c;
      iss_pc_o <= pc;
      {mem_valid_o, mem_store_o} <= m;
      mem_addr_o <= a;
      res_valid_o <= r;
      res_id_o <= id;
      @(posedge clk_i);
      {iss_valid_o, mem_valid_o, res_valid_o} <= 3'h0;
      iss_pc_o <= ~pc;
      mem_addr_o <= ~a;
      res_id_o <= ~id;
    end
  endtask
endmodule

// *** testbench/dbw_unit_tb.sv ***
// Register and pipeline scenarios for the debug breakpoint unit
`timescale 1ns/10ps
module dbw_unit_tb;
  reg clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cfg_req_i, cfg_we_i, cfg_write_lock_i;
  reg [9:0] wb_adr_i;
  reg [3:0] wb_sel_i;
  reg [31:0] wb_dat_i, cfg_wdata_i;
  reg [2:0] cfg_idx_i;
  wire [31:0] wb_dat_o, cfg_rdata_o, iss_pc, mem_addr, res_id;
  wire wb_ack_o, iss_valid, mem_valid, mem_store, res_valid, dbg_mode, dbg_req_o, irq_o;
  wire [2:0] iss_core;
  wire [7:0] core_run_ok_o;
  reg [31:0] q;
  integer error_cnt, cmp_count;
  dbw_unit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg_req_i(cfg_req_i), .cfg_we_i(cfg_we_i),
    .cfg_idx_i(cfg_idx_i), .cfg_wdata_i(cfg_wdata_i), .cfg_write_lock_i(cfg_write_lock_i),
    .cfg_rdata_o(cfg_rdata_o), .iss_valid_i(iss_valid), .iss_core_i(iss_core),
    .iss_pc_i(iss_pc), .mem_valid_i(mem_valid), .mem_store_i(mem_store),
    .mem_addr_i(mem_addr), .res_valid_i(res_valid), .res_id_i(res_id),
    .debug_mode_i(dbg_mode), .dbg_req_o(dbg_req_o), .core_run_ok_o(core_run_ok_o),
    .irq_o(irq_o));
  dbw_pipe_model pipe (.clk_i(clk_i), .iss_valid_o(iss_valid), .iss_core_o(iss_core),
    .iss_pc_o(iss_pc), .mem_valid_o(mem_valid), .mem_store_o(mem_store),
    .mem_addr_o(mem_addr), .res_valid_o(res_valid), .res_id_o(res_id),
    .dbg_mode_o(dbg_mode));
  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  task give_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chkb(input string nm, input e, input g);
    begin
      chk(nm, {31'h0, e}, {31'h0, g});
    end
  endtask
  // Classic single cycle, held until ack is sampled high
  task bus(input w, input [7:0] i, input [31:0] d);
    begin
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
      wb_adr_i <= {i, 2'h0};
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'h1)
        @(posedge clk_i);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      #1;
    end
  endtask
  task rd(input [7:0] i, input [31:0] e);
    begin
      bus(1'h0, i, 32'h0);
      chk("read", e, q);
    end
  endtask
  // Config side: read data lands the cycle after the strobe
  task cfg(input w, input [2:0] i, input [31:0] d);
    begin
      @(posedge clk_i);
      {cfg_req_i, cfg_we_i, cfg_idx_i, cfg_wdata_i} <= {1'h1, w, i, d};
      @(posedge clk_i);
      cfg_req_i <= 1'h0;
      #1;
      if (!w)
        chk("cfg_rdata", d, cfg_rdata_o);
    end
  endtask
  task hit(input [2:0] c, input [31:0] pc, input [1:0] m, input [31:0] a,
      input r, input [31:0] id, input e);
    begin
      pipe.issue(c, pc, m, a, r, id);
      #1;
      chkb("dbg_req", e, dbg_req_o);
    end
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    #40000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
  initial begin
    {error_cnt, cmp_count} = 64'h0;
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cfg_req_i, cfg_we_i, cfg_write_lock_i} = 7'h40;
    {wb_adr_i, wb_dat_i, cfg_idx_i, cfg_wdata_i} = 77'h0;
    wb_sel_i = 4'hF;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(8'h40, 32'h0);
    rd(8'h73, 32'h0);
    rd(8'h9F, 32'h0);
    rd(8'hB0, 32'h0);
    bus(1'h1, 8'h27, 32'hCAFE0127);
    cfg(1'h0, 3'h7, 32'hCAFE0127);
    cfg_write_lock_i <= 1'h1;
    cfg(1'h1, 3'h0, 32'h11);
    rd(8'h20, 32'h0);
    cfg_write_lock_i <= 1'h0;
    cfg(1'h1, 3'h0, 32'h5A5A0F0F);
    rd(8'h20, 32'h5A5A0F0F);
    bus(1'h1, 8'h16, 32'h0BAD0016);
    rd(8'h16, 32'h0BAD0016);
    bus(1'h1, 8'h18, 32'hA5);
    @(posedge clk_i);
    #1;
    chk("run_ok", 32'h5A, {24'h0, core_run_ok_o});
    rd(8'h18, 32'hA5);
    bus(1'h1, 8'h30, 32'h100);
    rd(8'h30, 32'h100);
    bus(1'h1, 8'h40, 32'h00040001);
    bus(1'h1, 8'hA2, 32'h1);
    hit(3'h2, 32'h100, 2'h0, 32'h0, 1'h0, 32'h0, 1'h1);
    rd(8'hA0, 32'h3);
    chkb("irq", 1'h1, irq_o);
    bus(1'h1, 8'hA1, 32'h1);
    chkb("irq", 1'h0, irq_o);
    bus(1'h1, 8'hA2, 32'h0);
    hit(3'h3, 32'h100, 2'h0, 32'h0, 1'h0, 32'h0, 1'h0);
    hit(3'h2, 32'h104, 2'h0, 32'h0, 1'h0, 32'h0, 1'h0);
    bus(1'h1, 8'h40, 32'h00040003);
    hit(3'h2, 32'h104, 2'h0, 32'h0, 1'h0, 32'h0, 1'h1);
    hit(3'h2, 32'h100, 2'h0, 32'h0, 1'h0, 32'h0, 1'h0);
    @(posedge clk_i);
    pipe.dbg_mode_o <= 1'h1;
    hit(3'h2, 32'h104, 2'h0, 32'h0, 1'h0, 32'h0, 1'h0);
    chk("run_ok", 32'hFF, {24'h0, core_run_ok_o});
    rd(8'hA3, 32'h1);
    @(posedge clk_i);
    pipe.dbg_mode_o <= 1'h0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("run_ok", 32'h5A, {24'h0, core_run_ok_o});
    bus(1'h1, 8'h40, 32'h0);
    bus(1'h1, 8'h31, 32'h200);
    bus(1'h1, 8'h32, 32'h200);
    bus(1'h1, 8'h41, 32'h00010001);
    bus(1'h1, 8'h42, 32'h00010001);
    hit(3'h0, 32'h200, 2'h0, 32'h0, 1'h0, 32'h0, 1'h1);
    rd(8'hA0, 32'h00010003);
    bus(1'h1, 8'h50, 32'h1000);
    bus(1'h1, 8'h60, 32'h1010);
    bus(1'h1, 8'h70, 32'h00010001);
    hit(3'h0, 32'h0, 2'h3, 32'h1010, 1'h0, 32'h0, 1'h1);
    rd(8'h16, 32'h1010);
    rd(8'hA0, 32'h4);
    hit(3'h0, 32'h0, 2'h2, 32'h1000, 1'h0, 32'h0, 1'h0);
    bus(1'h1, 8'h70, 32'h00010005);
    hit(3'h0, 32'h0, 2'h2, 32'h1000, 1'h0, 32'h0, 1'h1);
    hit(3'h0, 32'h0, 2'h3, 32'h1011, 1'h0, 32'h0, 1'h0);
    bus(1'h1, 8'h50, 32'h1010);
    bus(1'h1, 8'h60, 32'h1000);
    bus(1'h1, 8'h70, 32'h00010003);
    hit(3'h0, 32'h0, 2'h3, 32'h1000, 1'h0, 32'h0, 1'h0);
    hit(3'h0, 32'h0, 2'h3, 32'hFFF, 1'h0, 32'h0, 1'h1);
    hit(3'h0, 32'h0, 2'h3, 32'h1011, 1'h0, 32'h0, 1'h1);
    bus(1'h1, 8'h80, 32'hFF00);
    bus(1'h1, 8'h90, 32'h1200);
    bus(1'h1, 8'h9C, 32'h00010001);
    hit(3'h0, 32'h0, 2'h0, 32'h0, 1'h1, 32'h12FF, 1'h1);
    rd(8'h16, 32'h12FF);
    rd(8'hA0, 32'h5);
    hit(3'h0, 32'h0, 2'h0, 32'h0, 1'h1, 32'h13FF, 1'h0);
    bus(1'h1, 8'h9C, 32'h00010003);
    hit(3'h0, 32'h0, 2'h0, 32'h0, 1'h1, 32'h12FF, 1'h0);
    hit(3'h0, 32'h0, 2'h0, 32'h0, 1'h1, 32'h13FF, 1'h1);
    chkb("irq", 1'h0, irq_o);
    // Every class has set its sticky bit; clear two, keep one
    rd(8'hA1, 32'h7);
    bus(1'h1, 8'hA1, 32'h6);
    rd(8'hA1, 32'h1);
    bus(1'h1, 8'hA2, 32'h1);
    chkb("irq", 1'h1, irq_o);
    // Reset in mid-run brings everything back to its reset state
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    #1;
    chkb("irq", 1'h0, irq_o);
    chk("run_ok", 32'hFF, {24'h0, core_run_ok_o});
    rd(8'hA1, 32'h0);
    rd(8'h70, 32'h0);
    rd(8'h9C, 32'h0);
    give_verdict;
  end
endmodule
